// ---- ptpa_pkg.sv ----
/*
  Shared constants and types for the periodic tick and pulse accumulator
  timer block: register offsets, flag bit positions, readable masks,
  divider sizes and the packed carriers used on the register port.
  Assumes a single bus clock and byte-wide registers.
*/
`default_nettype none

package ptpa_pkg;

  // register port sizes
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 8;

  // register offsets
  localparam logic [REG_ADDR_W-1:0] ADDR_IRQ_ENABLE_TWO = 4'h0;
  localparam logic [REG_ADDR_W-1:0] ADDR_EVENT_FLAGS_TWO = 4'h1;
  localparam logic [REG_ADDR_W-1:0] ADDR_ACCUM_CONTROL = 4'h2;
  localparam logic [REG_ADDR_W-1:0] ADDR_ACCUM_COUNT = 4'h3;

  // flag and enable bit positions, shared by both registers
  localparam int BIT_COUNTER_WRAP = 7;
  localparam int BIT_TICK = 6;
  localparam int BIT_ACCUM_WRAP = 5;
  localparam int BIT_ACCUM_EDGE = 4;

  // bits that exist in each register; all others read as zero
  localparam logic [REG_DATA_W-1:0] IRQ_ENABLE_TWO_MASK = 8'hF3;
  localparam logic [REG_DATA_W-1:0] EVENT_FLAGS_TWO_MASK = 8'hF0;
  localparam logic [REG_DATA_W-1:0] ACCUM_CONTROL_MASK = 8'h77;
  localparam logic [REG_DATA_W-1:0] REG_RESET_VALUE = 8'h00;
  localparam logic [REG_DATA_W-1:0] READ_IDLE_VALUE = 8'h00;

  // tick divider: base stage plus up to three extra binary stages
  localparam int TICK_BASE_LOG2_DEF = 13;
  localparam int TICK_SEL_STAGES = 3;
  localparam logic [1:0] TICK_SEL_TOP = 2'h3;

  // gated accumulation time base is bus clock over 2^6
  localparam int GATE_DIV_LOG2 = 6;

  // free-running count and its prescaler
  localparam int FREE_COUNT_W = 16;
  localparam logic [FREE_COUNT_W-1:0] FREE_COUNT_MAX = 16'hFFFF;
  localparam int PRESCALE_W = 4;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MASK_DIV1 = 4'h0;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MASK_DIV4 = 4'h3;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MASK_DIV8 = 4'h7;
  localparam logic [PRESCALE_W-1:0] PRESCALE_MASK_DIV16 = 4'hF;

  // accumulator
  localparam int ACCUM_W = 8;
  localparam logic [ACCUM_W-1:0] ACCUM_MAX = 8'hFF;

  // accumulator operating mode
  typedef enum logic {
    ACC_EVENT_COUNT,
    ACC_GATED_TIME
  } ptpa_acc_mode_e;

  // one register port request
  typedef struct packed {
    logic [REG_ADDR_W-1:0] addr;
    logic [REG_DATA_W-1:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } ptpa_bus_req_s;

  // accumulator control register layout
  typedef struct packed {
    logic portBit7;
    logic accumEnable;
    ptpa_acc_mode_e accumGateMode;
    logic accumEdgePolarity;
    logic portBit3;
    logic capture4Compare5Select;
    logic [1:0] tickRateSelect;
  } ptpa_acc_ctrl_s;

  // second interrupt enable register layout
  typedef struct packed {
    logic counterWrapIrqEnable;
    logic tickIrqEnable;
    logic accumWrapIrqEnable;
    logic accumEdgeIrqEnable;
    logic [1:0] spare;
    logic [1:0] timerPrescaleSelect;
  } ptpa_irq_en_s;

endpackage

`default_nettype wire

// ---- ptpa_sync.sv ----
/*
  Three-stage input synchroniser with agreement filter for one pin.
  Assumes the pin is asynchronous to clock; the level output changes
  only once the second and third stages agree.
*/
`timescale 1ns/1ns
`default_nettype none

module ptpa_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // asynchronous pin
  input wire logic pinAsync,
  // filtered level in the clock domain
  output logic levelSync
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;

  // stage one is read by stage two only
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_r <= RESET_LEVEL;
      stage2_r <= RESET_LEVEL;
      stage3_r <= RESET_LEVEL;
    end
    else
    begin
      stage1_r <= pinAsync;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
    end
  end

  // accept a level only when the last two stages agree
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      levelSync <= RESET_LEVEL;
    else if (stage2_r == stage3_r)
      levelSync <= stage3_r;
  end

endmodule

`default_nettype wire

// ---- ptpa_timer.sv ----
/*
  Periodic tick generator, 16-bit free-running count with wrap flag and
  8-bit pulse accumulator, with the second timer enable and flag
  registers and the accumulator control and count registers.
  Assumes one bus clock, a register port with one-cycle strobes and
  read data one cycle later, and an asynchronous accumulator input pin.
*/
// Overview of operation
// - tick every bus clock over 2^13, 2^14, 2^15 or 2^16 by rate select
// - tick base divider ignores the timer prescaler setting
// - tick divider free-runs, stopped only by reset, not by flag clear
// - every tick sets the tick flag; request while flag and enable set
// - first tick flag comes one whole period after reset
// - tick flag is bit 6 of the flag register, cleared by writing one
// - every flag in the flag register clears by writing one to it
// - counter wrap flag sets when free-running count goes from max to 0
// - counter wrap enable high requests interrupt while wrap flag set
// - upper four enable bits gate the flags in the same positions
// - accumulator enable bit: zero disables, one enables
// - mode bit: zero event counting, one gated time accumulation
// - event mode counts falling edges, or rising edges with polarity one
// - gated mode counts a bus clock over 64 tick while the pin is active
// - gated mode: polarity zero inhibits on low pin, one on high pin
// - count readable and writable any time, untouched by reset
// - count update and count read never collide in one cycle
// - accumulator wrap flag sets on 0xFF to 0x00, bit 5 write clears
// - wrap enable never alters the flag; set enable requests interrupt
// - edge flag sets on each selected pin edge while enabled, bit 4 write clears
// - edge enable does not touch the flag; set enable requests interrupt
// - select bit zero enables fifth compare, one fourth capture
`timescale 1ns/1ns
`default_nettype none

module ptpa_timer #(
  parameter int TICK_BASE_LOG2 = ptpa_pkg::TICK_BASE_LOG2_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire ptpa_pkg::ptpa_bus_req_s busReq,
  output logic [ptpa_pkg::REG_DATA_W-1:0] rdData,
  // accumulator input pin
  input wire logic accumInputPin,
  // status towards the rest of the timer and the core
  output logic irqRequest,
  output logic periodicTick,
  output logic capture4Compare5Select,
  output logic [ptpa_pkg::FREE_COUNT_W-1:0] freeRunningCount
);

  import ptpa_pkg::*;

  localparam int DIV_W = TICK_BASE_LOG2 + TICK_SEL_STAGES;

  // register state
  ptpa_irq_en_s irqEnable_r;
  ptpa_acc_ctrl_s accumControl_r;
  logic [ACCUM_W-1:0] accumulatorCount_r;
  logic counterWrapFlag_r;
  logic tickFlag_r;
  logic accumWrapFlag_r;
  logic accumEdgeFlag_r;

  // dividers and counters
  logic [DIV_W-1:0] tickDiv_r;
  logic [DIV_W-1:0] tickMask;
  logic tickHit;
  logic gateTick;
  logic [PRESCALE_W-1:0] prescale_r;
  logic [PRESCALE_W-1:0] prescaleMask;
  logic prescaleHit;
  logic freeWrap;

  // pin path
  logic pinLevel;
  logic pinLevelPrev_r;
  logic pinRise;
  logic pinFall;
  logic selectedEdge;
  logic gateActive;

  // accumulator control
  logic accumIncrement;
  logic accumWrap;
  logic countWrite;

  // register decode
  logic wrIrqEnable;
  logic wrFlags;
  logic wrAccumControl;
  logic [REG_DATA_W-1:0] flagsView;
  logic [REG_DATA_W-1:0] irqTerms;
  logic [REG_DATA_W-1:0] readValue;

  // write decode
  always_comb
  begin
    wrIrqEnable = busReq.wrStrobe && (busReq.addr == ADDR_IRQ_ENABLE_TWO);
    wrFlags = busReq.wrStrobe && (busReq.addr == ADDR_EVENT_FLAGS_TWO);
    wrAccumControl = busReq.wrStrobe && (busReq.addr == ADDR_ACCUM_CONTROL);
    countWrite = busReq.wrStrobe && (busReq.addr == ADDR_ACCUM_COUNT);
  end

  // enable register; unimplemented bits are never stored
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irqEnable_r <= ptpa_irq_en_s'(REG_RESET_VALUE);
    else if (wrIrqEnable)
      irqEnable_r <= ptpa_irq_en_s'(busReq.wrData & IRQ_ENABLE_TWO_MASK);
  end

  // accumulator control register; port direction bits live elsewhere
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      accumControl_r <= ptpa_acc_ctrl_s'(REG_RESET_VALUE);
    else if (wrAccumControl)
      accumControl_r <= ptpa_acc_ctrl_s'(busReq.wrData & ACCUM_CONTROL_MASK);
  end

  // capture or compare selection goes out to the channel logic
  assign capture4Compare5Select = accumControl_r.capture4Compare5Select;

  // tick divider restarts only at reset; flag clears do not touch it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      tickDiv_r <= '0;
    else
      tickDiv_r <= tickDiv_r + 1'b1;
  end

  // the rate select keeps 13 to 16 low divider bits in the match
  always_comb
  begin
    tickMask = {DIV_W{1'b1}} >> (TICK_SEL_TOP - accumControl_r.tickRateSelect);
    tickHit = (tickDiv_r & tickMask) == tickMask;
    gateTick = &tickDiv_r[GATE_DIV_LOG2-1:0];
  end

  // divider starts at zero, so the first match is a whole period away
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      periodicTick <= 1'b0;
    else
      periodicTick <= tickHit;
  end

  // prescaler for the free-running count, separate from the tick chain
  always_comb
  begin
    unique case (irqEnable_r.timerPrescaleSelect)
      2'h0: prescaleMask = PRESCALE_MASK_DIV1;
      2'h1: prescaleMask = PRESCALE_MASK_DIV4;
      2'h2: prescaleMask = PRESCALE_MASK_DIV8;
      2'h3: prescaleMask = PRESCALE_MASK_DIV16;
    endcase
    prescaleHit = (prescale_r & prescaleMask) == prescaleMask;
    freeWrap = prescaleHit && (freeRunningCount == FREE_COUNT_MAX);
  end

  // prescaler counter
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      prescale_r <= '0;
    else
      prescale_r <= prescale_r + 1'b1;
  end

  // free-running count, advanced once per prescaled step
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      freeRunningCount <= '0;
    else if (prescaleHit)
      freeRunningCount <= freeRunningCount + 1'b1;
  end

  // pin goes through three stages and a filter flop; the filter starts at the idle high level
  ptpa_sync #(
    .RESET_LEVEL(1'b1)
  ) u_pinSync (
    .clock(clock),
    .rstn(rstn),
    .pinAsync(accumInputPin),
    .levelSync(pinLevel)
  );

  // previous filtered level for edge detection
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      pinLevelPrev_r <= 1'b1; // same as the filter, so no edge at release
    else
      pinLevelPrev_r <= pinLevel;
  end

  // edge choice and gate level both follow the polarity bit
  always_comb
  begin
    pinRise = pinLevel && !pinLevelPrev_r;
    pinFall = !pinLevel && pinLevelPrev_r;
    selectedEdge = accumControl_r.accumEdgePolarity ? pinRise : pinFall;
    gateActive = accumControl_r.accumEdgePolarity ? !pinLevel : pinLevel;
  end

  // count source by mode; nothing counts while disabled
  always_comb
  begin
    accumIncrement = 1'b0;
    if (accumControl_r.accumEnable)
    begin
      unique case (accumControl_r.accumGateMode)
        ACC_EVENT_COUNT: accumIncrement = selectedEdge;
        ACC_GATED_TIME: accumIncrement = gateTick && gateActive;
      endcase
    end
    // a software write in the same cycle takes the count instead
    accumWrap = accumIncrement && !countWrite &&
                (accumulatorCount_r == ACCUM_MAX);
  end

  // count has no reset: software owns its value across resets
  // writes win over an increment in the same cycle, so a read never
  // sees a half-updated value and writes are never lost
  always_ff @(posedge clock)
  begin
    if (countWrite)
      accumulatorCount_r <= busReq.wrData;
    else if (accumIncrement)
      accumulatorCount_r <= accumulatorCount_r + 1'b1;
  end

  // counter wrap flag; a set in the clearing cycle survives
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      counterWrapFlag_r <= 1'b0;
    else if (freeWrap)
      counterWrapFlag_r <= 1'b1;
    else if (wrFlags && busReq.wrData[BIT_COUNTER_WRAP])
      counterWrapFlag_r <= 1'b0;
  end

  // tick flag; clearing it leaves the divider running
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      tickFlag_r <= 1'b0;
    else if (tickHit)
      tickFlag_r <= 1'b1;
    else if (wrFlags && busReq.wrData[BIT_TICK])
      tickFlag_r <= 1'b0;
  end

  // accumulator wrap flag; the enable bit never reaches it
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      accumWrapFlag_r <= 1'b0;
    else if (accumWrap)
      accumWrapFlag_r <= 1'b1;
    else if (wrFlags && busReq.wrData[BIT_ACCUM_WRAP])
      accumWrapFlag_r <= 1'b0;
  end

  // edge flag in either mode, but only while the accumulator is on
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      accumEdgeFlag_r <= 1'b0;
    else if (accumControl_r.accumEnable && selectedEdge)
      accumEdgeFlag_r <= 1'b1;
    else if (wrFlags && busReq.wrData[BIT_ACCUM_EDGE])
      accumEdgeFlag_r <= 1'b0;
  end

  // flag register image; low nibble stays zero
  always_comb
  begin
    flagsView = '0;
    flagsView[BIT_COUNTER_WRAP] = counterWrapFlag_r;
    flagsView[BIT_TICK] = tickFlag_r;
    flagsView[BIT_ACCUM_WRAP] = accumWrapFlag_r;
    flagsView[BIT_ACCUM_EDGE] = accumEdgeFlag_r;
  end

  // one request term per flag, each gated by the enable in its position;
  // enables reach only the request, so polling sees the same flags
  always_comb
  begin
    irqTerms = '0;
    irqTerms[BIT_COUNTER_WRAP] = counterWrapFlag_r &&
                                 irqEnable_r.counterWrapIrqEnable;
    irqTerms[BIT_TICK] = tickFlag_r && irqEnable_r.tickIrqEnable;
    irqTerms[BIT_ACCUM_WRAP] = accumWrapFlag_r &&
                               irqEnable_r.accumWrapIrqEnable;
    irqTerms[BIT_ACCUM_EDGE] = accumEdgeFlag_r &&
                               irqEnable_r.accumEdgeIrqEnable;
  end

  // registered request; a flag cleared now drops it one cycle later
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      irqRequest <= 1'b0;
    else
      irqRequest <= |(irqTerms & EVENT_FLAGS_TWO_MASK);
  end

  // read mux; unmapped offsets read zero
  always_comb
  begin
    unique case (busReq.addr)
      ADDR_IRQ_ENABLE_TWO: readValue = REG_DATA_W'(irqEnable_r);
      ADDR_EVENT_FLAGS_TWO: readValue = flagsView;
      ADDR_ACCUM_CONTROL: readValue = REG_DATA_W'(accumControl_r);
      ADDR_ACCUM_COUNT: readValue = accumulatorCount_r;
      default: readValue = READ_IDLE_VALUE;
    endcase
  end

  // read data stand only in the cycle after the read strobe
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      rdData <= READ_IDLE_VALUE;
    else if (busReq.rdStrobe)
      rdData <= readValue;
    else
      rdData <= READ_IDLE_VALUE;
  end

endmodule

`default_nettype wire

// ---- ptpa_timer_assertions.sv ----
/*
  Port checker for the tick and accumulator timer block.
  Assumes one bus clock and the register map of ptpa_pkg.
*/
`timescale 1ns/1ns
`default_nettype none

module ptpa_timer_assertions
  import ptpa_pkg::*;
#(
  parameter int TICK_BASE_LOG2 = TICK_BASE_LOG2_DEF
) (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // register port
  input wire ptpa_pkg::ptpa_bus_req_s busReq,
  input wire logic [ptpa_pkg::REG_DATA_W-1:0] rdData,
  // status
  input wire logic irqRequest,
  input wire logic periodicTick,
  input wire logic capture4Compare5Select,
  input wire logic [ptpa_pkg::FREE_COUNT_W-1:0] freeRunningCount
);
  logic [19:0] ageR;
  logic [3:0] enR;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rstn);

  // cycle age since release and a copy of the upper enables
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ageR <= '0;
      enR <= '0;
    end
    else
    begin
      ageR <= ageR + 20'h00001;
      if (busReq.wrStrobe && busReq.addr == ADDR_IRQ_ENABLE_TWO)
        enR <= busReq.wrData[7:4];
    end
  end

  // every rate is a multiple of the base, so ticks sit on its grid
  property p_tick_phase;
    periodicTick |-> ageR[TICK_BASE_LOG2-1:0] == '0 && ageR != '0;
  endproperty
  a_tick_phase: assert property (p_tick_phase)
    else $error("tick off the base grid");

  property p_count_step;
    freeRunningCount != $past(freeRunningCount) |->
      freeRunningCount == $past(freeRunningCount) + 16'h0001;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("free count jumped");

  property p_unmapped;
    busReq.rdStrobe && busReq.addr > ADDR_ACCUM_COUNT |=> rdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  property p_flag_low;
    busReq.rdStrobe && busReq.addr == ADDR_EVENT_FLAGS_TWO |=>
      rdData[3:0] == 4'h0;
  endproperty
  a_flag_low: assert property (p_flag_low)
    else $error("flag low bits not zero");

  property p_en_low;
    busReq.rdStrobe && busReq.addr == ADDR_IRQ_ENABLE_TWO |=>
      rdData[3:2] == 2'h0;
  endproperty
  a_en_low: assert property (p_en_low)
    else $error("enable spare bits not zero");

  property p_sel_bit;
    busReq.wrStrobe && busReq.addr == ADDR_ACCUM_CONTROL |=>
      capture4Compare5Select == $past(busReq.wrData[2]);
  endproperty
  a_sel_bit: assert property (p_sel_bit)
    else $error("select bit not taken");

  property p_irq_quiet;
    enR == 4'h0 && $past(enR) == 4'h0 |-> !irqRequest;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("request with all enables off");

  // flag lands with the tick, the request one cycle later
  property p_tick_irq;
    periodicTick && enR[2] && $past(enR[2]) |=> irqRequest;
  endproperty
  a_tick_irq: assert property (p_tick_irq)
    else $error("tick request missing");

  property p_rd_idle;
    rdData != 8'h00 |-> $past(busReq.rdStrobe);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
endmodule

bind ptpa_timer ptpa_timer_assertions #(
  .TICK_BASE_LOG2(TICK_BASE_LOG2)
) chk (
  .clock(clock),
  .rstn(rstn),
  .busReq(busReq),
  .rdData(rdData),
  .irqRequest(irqRequest),
  .periodicTick(periodicTick),
  .capture4Compare5Select(capture4Compare5Select),
  .freeRunningCount(freeRunningCount)
);

`default_nettype wire

// ---- ptpa_pulse_src.sv ----
/*
  External pulse source for the accumulator input pin.
  Assumes a one-cycle go; each pulse is a dip and a return.
*/
`timescale 1ns/1ns
`default_nettype none

module ptpa_pulse_src #(
  parameter logic [7:0] HALF = 8'h04
) (
  // clock
  input wire logic clock,
  // burst request
  input wire logic go,
  input wire logic [7:0] nPulse,
  input wire logic idleLevel,
  // pin and status
  output logic pin,
  output logic busy
);
  logic [8:0] edgesR = '0;
  logic [7:0] lenR = '0;

  initial pin = 1'b1;

  // phases of HALF plus one cycles stay clear of the input filter limit
  always @(posedge clock)
  begin
    if (go)
    begin
      edgesR <= {nPulse, 1'b0};
      lenR <= HALF;
    end
    else if (edgesR == 9'h000)
      pin <= idleLevel;
    else if (lenR == 8'h00)
    begin
      pin <= !pin;
      edgesR <= edgesR - 9'h001;
      lenR <= HALF;
    end
    else
      lenR <= lenR - 8'h01;
  end

  assign busy = go || edgesR != 9'h000;
endmodule

`default_nettype wire

// ---- tb_periodic_tick_and_pulse_accumulator.sv ----
/*
  Self-checking bench for ptpa_timer with a pulse source on its pin.
  Assumes a short tick base so every rate fits the run.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_periodic_tick_and_pulse_accumulator;
  import ptpa_pkg::*;
  logic clock = 1'b0;
  logic rstn;
  ptpa_bus_req_s busReq;
  logic [7:0] rdData;
  logic irqRequest, periodicTick, pin, busy, go, pinLevel, selOut;
  logic [7:0] nPulse, seed, cnt;
  logic [15:0] freeRunningCount;
  logic [23:0] expQ[$];
  logic rdSeen = 1'b0;
  int nFail = 0;
  int cmpCount = 0;
  int cyc = 0;
  int i, t0;

  ptpa_timer #(.TICK_BASE_LOG2(7)) uut (
    .clock(clock), .rstn(rstn), .busReq(busReq), .rdData(rdData),
    .accumInputPin(pin), .irqRequest(irqRequest),
    .periodicTick(periodicTick), .capture4Compare5Select(selOut),
    .freeRunningCount(freeRunningCount));
  ptpa_pulse_src src (.clock(clock), .go(go), .nPulse(nPulse),
    .idleLevel(pinLevel), .pin(pin), .busy(busy));

  always #50 clock = !clock;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic stopTest;
    $display("comparisons %0d mismatches %0d", cmpCount, nFail);
    if (nFail == 0 && cmpCount > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic cmpv(input logic [15:0] g, input logic [15:0] e);
    cmpCount++;
    if (g !== e)
    begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // note is mask, low and high bound of the masked read value
  task automatic chk(input logic [7:0] g, input logic [23:0] e);
    logic ok;
    ok = (g & e[23:16]) >= e[15:8] && (g & e[23:16]) <= e[7:0];
    cmpCount++;
    if (ok !== 1'b1)
    begin
      nFail++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq.addr <= a;
    busReq.wrData <= d;
    busReq.wrStrobe <= 1'b1;
    @(posedge clock);
    busReq.wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] m, lo, hi);
    @(posedge clock);
    busReq.addr <= a;
    busReq.rdStrobe <= 1'b1;
    expQ.push_back({m, lo, hi});
    @(posedge clock);
    busReq.rdStrobe <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] n);
    @(posedge clock);
    nPulse <= n;
    go <= 1'b1;
    @(posedge clock);
    go <= 1'b0;
    @(negedge clock);
    while (busy)
      @(negedge clock);
    repeat (8) @(negedge clock);
  endtask

  task automatic waitTick;
    @(negedge clock);
    while (periodicTick !== 1'b1)
      @(negedge clock);
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge clock)
  begin
    if (rdSeen)
      chk(rdData, expQ.pop_front());
    rdSeen <= busReq.rdStrobe;
  end

  // hang guard
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      nFail++;
      stopTest();
    end
  end

  initial
  begin
    busReq = '0;
    go = 1'b0;
    nPulse = 8'h00;
    pinLevel = 1'b1;
    seed = 8'h5E;
    rstn = 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    wr(4'h9, 8'hFF);
    for (i = 0; i < 16; i++)
      if (i != 3)
        rd(i[3:0], 8'hFF, 8'h00, 8'h00);
    wr(ADDR_IRQ_ENABLE_TWO, 8'h0F);
    rd(ADDR_IRQ_ENABLE_TWO, 8'hFF, 8'h03, 8'h03);
    wr(ADDR_ACCUM_CONTROL, 8'hFF);
    rd(ADDR_ACCUM_CONTROL, 8'hFF, 8'h77, 8'h77);
    cmpv({15'h0000, selOut}, 16'h0001);
    wr(ADDR_IRQ_ENABLE_TWO, 8'h40);
    // flag clears mid-period must not move the next tick
    for (i = 0; i < 4; i++)
    begin
      wr(ADDR_ACCUM_CONTROL, i[7:0]);
      waitTick();
      t0 = cyc;
      wr(ADDR_EVENT_FLAGS_TWO, 8'h00);
      rd(ADDR_EVENT_FLAGS_TWO, 8'h40, 8'h40, 8'h40);
      cmpv({15'h0000, irqRequest}, 16'h0001);
      wr(ADDR_EVENT_FLAGS_TWO, 8'h40);
      rd(ADDR_EVENT_FLAGS_TWO, 8'h40, 8'h00, 8'h00);
      cmpv({15'h0000, irqRequest}, 16'h0000);
      waitTick();
      cmpv(16'(cyc - t0), 16'h0080 << i);
    end
    wr(ADDR_IRQ_ENABLE_TWO, 8'h30);
    for (i = 0; i < 2; i++)
    begin
      seed = lfsr(seed);
      cnt = 8'hFC | seed;
      wr(ADDR_ACCUM_CONTROL, 8'h40 | (i[7:0] << 4));
      wr(ADDR_ACCUM_COUNT, cnt);
      wr(ADDR_EVENT_FLAGS_TWO, 8'h30);
      pulse(8'h04);
      cnt = cnt + 8'h04;
      rd(ADDR_ACCUM_COUNT, 8'hFF, cnt, cnt);
      rd(ADDR_EVENT_FLAGS_TWO, 8'h30, 8'h30, 8'h30);
      cmpv({15'h0000, irqRequest}, 16'h0001);
    end
    wr(ADDR_ACCUM_CONTROL, 8'h00);
    wr(ADDR_EVENT_FLAGS_TWO, 8'h30);
    pulse(8'h03);
    rd(ADDR_ACCUM_COUNT, 8'hFF, cnt, cnt);
    rd(ADDR_EVENT_FLAGS_TWO, 8'h30, 8'h00, 8'h00);
    cmpv({15'h0000, irqRequest}, 16'h0000);
    // gated: inactive level holds, active level counts every 64
    for (i = 0; i < 2; i++)
    begin
      pinLevel <= i[0];
      wr(ADDR_ACCUM_CONTROL, 8'h60 | (i[7:0] << 4));
      repeat (10) @(negedge clock);
      wr(ADDR_ACCUM_COUNT, 8'h00);
      repeat (640) @(negedge clock);
      rd(ADDR_ACCUM_COUNT, 8'hFF, 8'h00, 8'h00);
      pinLevel <= !i[0];
      repeat (640) @(negedge clock);
      rd(ADDR_ACCUM_COUNT, 8'hFF, 8'h09, 8'h0B);
    end
    // reset in mid-run: count survives, first tick a whole period later
    seed = lfsr(seed);
    wr(ADDR_ACCUM_CONTROL, 8'h00);
    wr(ADDR_ACCUM_COUNT, seed);
    @(posedge clock);
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    @(negedge clock);
    t0 = cyc;
    rd(ADDR_ACCUM_COUNT, 8'hFF, seed, seed);
    waitTick();
    cmpv(16'(cyc - t0), 16'h0080);
    wr(ADDR_IRQ_ENABLE_TWO, 8'h80);
    wr(ADDR_EVENT_FLAGS_TWO, 8'hF0);
    while (freeRunningCount !== 16'hFFFF)
      @(negedge clock);
    repeat (3) @(negedge clock);
    cmpv({15'h0000, irqRequest}, 16'h0001);
    rd(ADDR_EVENT_FLAGS_TWO, 8'h80, 8'h80, 8'h80);
    repeat (3) @(posedge clock);
    stopTest();
  end
endmodule

`default_nettype wire
